// ### inc/mps_pkg.sv
// What this block does
// (RULE1) mode pin driven low for normal operation; high tristates outputs, special settings
// (RULE2) post divider code: 11 div2 default, 10 div4, 01 div8
// (RULE3) multiplier code: 10 x16, 11 x8 default, 00 x4, 01 x2
// (RULE4) default pin settings give a 200 MHz memory clock
// (RULE5) software may retune the memory clock, e.g. 50 or 100 MHz
// (RULE6) retune only with no memory fitted or controller clocked elsewhere
// (RULE7) reference from 50 MHz oscillator; fabric drive only when board modified
// (RULE8) fabric-driven reference uses its own output plus a feedback return
// (RULE9) memory clock is the memory controller system clock by default
// (RULE10) 66 MHz clock is configuration clock, later user system clock; the code times the settle at CLK_MHZ = 50 instead
// (RULE11) the same 66 MHz clock clocks the bridge local bus
// (RULE12) separate 200 MHz clock is the input-delay calibration reference
// (RULE13) pins static, f = ref*mult/div, changed only while downstream in reset
`default_nettype none
package mps_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STRAP = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_REFDIV = 8'h0c;
   localparam logic [1:0] POST_DIV2 = 2'h3;
   localparam logic [1:0] POST_DIV4 = 2'h2;
   localparam logic [1:0] POST_DIV8 = 2'h1;
   localparam logic [1:0] MULT_X16 = 2'h2;
   localparam logic [1:0] MULT_X8 = 2'h3;
   localparam logic [1:0] MULT_X4 = 2'h0;
   localparam logic [1:0] MULT_X2 = 2'h1;
   localparam logic MODE_NORMAL = 1'b0;
   // strap register fields
   localparam int STRAP_MODE_BIT = 0;
   localparam int STRAP_POST_LSB = 1;
   localparam int STRAP_MULT_LSB = 3;
   localparam logic [4:0] STRAP_RESET = {MULT_X8, POST_DIV2, MODE_NORMAL};
   // ctrl fields
   localparam int CTRL_APPLY_BIT = 0;
   localparam int CTRL_REFEN_BIT = 1;
   localparam int CTRL_MEMOK_BIT = 2;
   // status fields
   localparam int STATUS_RST_BIT = 5;
   localparam int STATUS_FBSEEN_BIT = 6;
   localparam int STATUS_REFUSED_BIT = 7;
   localparam int REF_MHZ = 50;
   localparam int CLK_MHZ = 50;
   // hold downstream reset this long around a strap change
   localparam int SETTLE_US = 100;
   localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
   localparam logic [7:0] REFDIV_RESET = 8'h00;
   typedef enum logic [1:0] {MPS_IDLE, MPS_ASSERT, MPS_SETTLE} mps_state_e;
endpackage
`default_nettype wire

// ### core/mps_refgen.sv
`default_nettype none
// reference clock generator: clock enable divider toggling an output
module mps_refgen (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic [7:0] half_period_in,
   output logic ref_out
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic ref_reg;
   logic ref_next;

   always_comb begin
      cnt_next = cnt_reg;
      ref_next = ref_reg;
      if (!enable_in) begin
         cnt_next = 8'h00;
         ref_next = 1'b0;
      end else if (cnt_reg >= half_period_in) begin
         cnt_next = 8'h00;
         ref_next = !ref_reg;
      end else begin
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         cnt_reg <= 8'h00;
         ref_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         ref_reg <= ref_next;
      end
   end

   assign ref_out = ref_reg;
endmodule
`default_nettype wire

// ### core/mps_top.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module mps_top #(
   parameter int SETTLE_CYCLES = mps_pkg::SETTLE_CYCLES
) (
   input wire logic clk_sys_in, // RULE10 RULE11 RULE12
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic fabric_pll_feedback_in,
   output logic pll_mode_select_out,
   output logic pll_post_divider_bit_a_out,
   output logic pll_post_divider_bit_b_out,
   output logic pll_multiplier_bit_a_out,
   output logic pll_multiplier_bit_b_out,
   output logic fabric_pll_reference_out,
   output logic memory_domain_reset_out
);
   logic [4:0] staged_reg, staged_next;
   logic [4:0] pins_reg, pins_next;
   logic refen_reg, refen_next;
   logic memok_reg, memok_next;
   logic [7:0] refdiv_reg, refdiv_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic apply_pulse;
   logic refused_reg, refused_next;
   mps_pkg::mps_state_e state_reg, state_next;
   logic [31:0] cnt_reg, cnt_next;
   logic rst_reg, rst_next;
   logic fb_q1_reg, fb_q2_reg, fb_seen_reg, fb_prev_reg;
   logic ref_raw;
   logic ref_q_reg;
   logic access;

   assign access = psel_in && penable_in && !pready_reg;

   // register writes and reads; one wait cycle per access
   always_comb begin
      staged_next = staged_reg;
      refen_next = refen_reg;
      memok_next = memok_reg;
      refdiv_next = refdiv_reg;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      apply_pulse = 1'b0;
      if (access) begin
         pready_next = 1'b1;
         prdata_next = 32'h0000_0000;
         unique case (paddr_in)
            mps_pkg::ADDR_CTRL: begin
               if (pwrite_in) begin
                  apply_pulse = pwdata_in[mps_pkg::CTRL_APPLY_BIT];
                  refen_next = pwdata_in[mps_pkg::CTRL_REFEN_BIT]; // RULE7
                  memok_next = pwdata_in[mps_pkg::CTRL_MEMOK_BIT];
               end
               prdata_next[mps_pkg::CTRL_REFEN_BIT] = refen_reg;
               prdata_next[mps_pkg::CTRL_MEMOK_BIT] = memok_reg;
            end
            mps_pkg::ADDR_STRAP: begin
               if (pwrite_in) begin
                  staged_next = pwdata_in[4:0]; // RULE5
               end
               prdata_next[4:0] = staged_reg;
            end
            mps_pkg::ADDR_STATUS: begin
               prdata_next[4:0] = pins_reg;
               prdata_next[mps_pkg::STATUS_RST_BIT] = rst_reg;
               prdata_next[mps_pkg::STATUS_FBSEEN_BIT] = fb_seen_reg;
               prdata_next[mps_pkg::STATUS_REFUSED_BIT] = refused_reg;
            end
            mps_pkg::ADDR_REFDIV: begin
               if (pwrite_in) begin
                  refdiv_next = pwdata_in[7:0];
               end
               prdata_next[7:0] = refdiv_reg;
            end
            default: begin
               pslverr_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         staged_reg <= mps_pkg::STRAP_RESET;
         refen_reg <= 1'b0;
         memok_reg <= 1'b0;
         refdiv_reg <= mps_pkg::REFDIV_RESET;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         staged_reg <= staged_next;
         refen_reg <= refen_next;
         memok_reg <= memok_next;
         refdiv_reg <= refdiv_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // strap change sequencer: hold memory reset, change pins, settle, release
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pins_next = pins_reg;
      rst_next = rst_reg;
      refused_next = refused_reg;
      unique case (state_reg)
         mps_pkg::MPS_IDLE: begin
            if (apply_pulse) begin
               // the permission bit written along with apply decides
               if (memok_next) begin // RULE6
                  state_next = mps_pkg::MPS_ASSERT;
                  rst_next = 1'b1; // RULE13
                  refused_next = 1'b0;
               end else begin
                  refused_next = 1'b1;
               end
            end
         end
         mps_pkg::MPS_ASSERT: begin
            pins_next = staged_reg; // RULE13
            cnt_next = 32'h0000_0000;
            state_next = mps_pkg::MPS_SETTLE;
         end
         mps_pkg::MPS_SETTLE: begin
            if (cnt_reg >= 32'(SETTLE_CYCLES - 1)) begin
               rst_next = 1'b0;
               state_next = mps_pkg::MPS_IDLE;
            end else begin
               cnt_next = cnt_reg + 32'h0000_0001;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_reg <= mps_pkg::MPS_IDLE;
         cnt_reg <= 32'h0000_0000;
         pins_reg <= mps_pkg::STRAP_RESET; // RULE4
         rst_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pins_reg <= pins_next;
         rst_reg <= rst_next;
         refused_reg <= refused_next;
      end
   end

   // fabric reference and feedback return
   mps_refgen u_refgen (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .enable_in(refen_reg),
      .half_period_in(refdiv_reg),
      .ref_out(ref_raw)
   );

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ref_q_reg <= 1'b0;
         fb_q1_reg <= 1'b0;
         fb_q2_reg <= 1'b0;
         fb_prev_reg <= 1'b0;
         fb_seen_reg <= 1'b0;
      end else begin
         ref_q_reg <= ref_raw; // RULE8
         fb_q1_reg <= fabric_pll_feedback_in;
         fb_q2_reg <= fb_q1_reg;
         fb_prev_reg <= fb_q2_reg;
         if (refen_reg && (fb_q2_reg != fb_prev_reg)) begin
            fb_seen_reg <= 1'b1; // RULE8
         end else if (!refen_reg) begin
            fb_seen_reg <= 1'b0;
         end
      end
   end

   assign pll_mode_select_out = pins_reg[mps_pkg::STRAP_MODE_BIT]; // RULE1
   assign pll_post_divider_bit_a_out = pins_reg[mps_pkg::STRAP_POST_LSB + 1]; // RULE2
   assign pll_post_divider_bit_b_out = pins_reg[mps_pkg::STRAP_POST_LSB];
   assign pll_multiplier_bit_a_out = pins_reg[mps_pkg::STRAP_MULT_LSB + 1]; // RULE3
   assign pll_multiplier_bit_b_out = pins_reg[mps_pkg::STRAP_MULT_LSB];
   assign fabric_pll_reference_out = ref_q_reg;
   assign memory_domain_reset_out = rst_reg; // RULE9
   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;

   a_pins_stable: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !rst_reg |=> $stable(pins_reg)) else $error("strap pins changed outside reset"); // RULE13
   a_default_pins: assert property (@(posedge clk_sys_in)
      (!reset_in && $past(reset_in)) |-> pins_reg == mps_pkg::STRAP_RESET)
      else $error("strap pins not default after reset"); // RULE4
   a_refuse_change: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (apply_pulse && !memok_next && state_reg == mps_pkg::MPS_IDLE) |=> refused_reg && !rst_reg)
      else $error("change accepted while memory in use"); // RULE6
   a_apply_reset: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (apply_pulse && memok_next && state_reg == mps_pkg::MPS_IDLE)
      |=> rst_reg ##1 (rst_reg && pins_reg == $past(staged_reg)))
      else $error("strap change not under reset"); // RULE13
   a_ref_off: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !refen_reg [*3] |-> !fabric_pll_reference_out) else $error("reference driven while disabled"); // RULE7
   a_apb_ready: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (psel_in && penable_in && !pready_reg) |=> pready_reg ##1 !pready_reg) else $error("ready not single pulse"); // RULE5
   a_mode_map: assert property (@(posedge clk_sys_in)
      (!reset_in && $past(reset_in)) |-> pll_mode_select_out == mps_pkg::MODE_NORMAL)
      else $error("mode pin not normal after reset"); // RULE1
   a_div_map: assert property (@(posedge clk_sys_in)
      (!reset_in && $past(reset_in)) |->
      {pll_post_divider_bit_a_out, pll_post_divider_bit_b_out} == mps_pkg::POST_DIV2)
      else $error("post div pins not divide by two after reset"); // RULE2
   a_mult_map: assert property (@(posedge clk_sys_in)
      (!reset_in && $past(reset_in)) |->
      {pll_multiplier_bit_a_out, pll_multiplier_bit_b_out} == mps_pkg::MULT_X8)
      else $error("mult pins not times eight after reset"); // RULE3
endmodule
`default_nettype wire

// ### verification/mps_pll_model.sv
`default_nettype none
module mps_pll_model #(
   parameter int REF_MHZ = 50
) (
   input wire logic mode_in,
   input wire logic post_a_in,
   input wire logic post_b_in,
   input wire logic mult_a_in,
   input wire logic mult_b_in,
   input wire logic ref_in,
   output logic feedback_out,
   output logic [15:0] mhz_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int mult;
   int div;
   always_comb begin
      case ({mult_a_in, mult_b_in})
         2'h2: mult = 16;
         2'h3: mult = 8;
         2'h0: mult = 4;
         default: mult = 2;
      endcase
      case ({post_a_in, post_b_in})
         2'h3: div = 2;
         2'h2: div = 4;
         default: div = 8;
      endcase
   end
   // high mode floats the outputs, seen as no clock at all
   assign mhz_out = mode_in ? 16'h0000 : 16'(REF_MHZ * mult / div);
   // board return path of the fabric-driven reference
   assign #2 feedback_out = ref_in;
endmodule
`default_nettype wire

// ### verification/mps_top_bench.sv
`default_nettype none
module mps_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic [31:0] prdata_out, rd;
   logic pready_out, pslverr_out, err, fb, refo, mrst, prev_refo;
   logic [4:0] pins, prev;
   logic [15:0] mhz;
   int fail_count = 0, compares = 0, cyc = 0, hi, tog;
   logic [20:0] rows [6] = '{{5'h1e, 16'd200}, {5'h14, 16'd200}, {5'h02, 16'd25},
                            {5'h0e, 16'd50}, {5'h1c, 16'd100}, {5'h1f, 16'd0}};
   mps_top #(.SETTLE_CYCLES(4)) mps_top_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .fabric_pll_feedback_in(fb),
      .pll_mode_select_out(pins[0]), .pll_post_divider_bit_a_out(pins[2]), .pll_post_divider_bit_b_out(pins[1]),
      .pll_multiplier_bit_a_out(pins[4]), .pll_multiplier_bit_b_out(pins[3]),
      .fabric_pll_reference_out(refo), .memory_domain_reset_out(mrst));
   mps_pll_model mps_pll_model_i (.mode_in(pins[0]), .post_a_in(pins[2]), .post_b_in(pins[1]),
      .mult_a_in(pins[4]), .mult_b_in(pins[3]), .ref_in(refo), .feedback_out(fb), .mhz_out(mhz));
   initial begin
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      // pready_out ends this wait; the bench timeout catches a hang
      do begin
         @(posedge clk_sys_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // applies the strap and watches that pins only move under memory reset
   task automatic apply(input logic [31:0] ctrl);
      hi = 0;
      apb(1'b1, mps_pkg::ADDR_CTRL, ctrl);
      prev = pins;
      repeat (16) begin
         @(posedge clk_sys_in);
         if (mrst === 1'b1) hi++;
         if (pins !== prev && mrst !== 1'b1) chk(32'h1, 32'h0);
         prev = pins;
      end
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      #1;
      chk({mhz, 9'h0, refo, mrst, pins}, {16'd200, 9'h0, 2'b00, mps_pkg::STRAP_RESET});
      apb(1'b0, mps_pkg::ADDR_REFDIV, 32'h0);
      chk(rd, {24'h0, mps_pkg::REFDIV_RESET});
      foreach (rows[i]) begin
         apb(1'b1, mps_pkg::ADDR_STRAP, {27'h0, rows[i][20:16]});
         apply(32'h5);
         chk({11'h0, pins, mhz}, {11'h0, rows[i]});
         chk({31'h0, hi >= 4 && hi <= 6}, 32'h1);
      end
      apb(1'b1, mps_pkg::ADDR_STRAP, 32'h1e);
      apply(32'h1);
      apb(1'b0, mps_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h9f);
      chk(hi, 0);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, mps_pkg::ADDR_REFDIV, 32'h1);
      apb(1'b1, mps_pkg::ADDR_CTRL, 32'h2);
      tog = 0;
      // let the divider and output register reach steady state
      repeat (4) @(posedge clk_sys_in);
      prev_refo = refo;
      repeat (16) begin
         @(posedge clk_sys_in);
         if (refo !== prev_refo) tog++;
         prev_refo = refo;
      end
      chk(tog, 8);
      apb(1'b0, mps_pkg::ADDR_STATUS, 32'h0);
      chk({31'h0, rd[mps_pkg::STATUS_FBSEEN_BIT]}, 32'h1);
      apb(1'b1, mps_pkg::ADDR_CTRL, 32'h0);
      repeat (4) @(posedge clk_sys_in);
      chk({31'h0, refo}, 32'h0);
      reset_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      #1;
      chk({11'h0, pins, mhz}, {11'h0, mps_pkg::STRAP_RESET, 16'd200});
      test_done();
   end
endmodule
`default_nettype wire
